/* File: hw/pwg_pkg.sv */
// package for the pwm waveform generator: register map, field layout, types
package pwg_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_IDENT = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_CFG = 8'h08;
	localparam logic [7:0] OFS_LAUNCH = 8'h0c;
	localparam logic [7:0] OFS_RPT = 8'h10;
	localparam logic [7:0] OFS_PER = 8'h14;
	localparam logic [7:0] OFS_PH1 = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
	localparam logic [7:0] OFS_STATE = 8'h24;

	// ----------------------------------------------------------------
	// identity (value is arbitrary)
	// ----------------------------------------------------------------
	localparam logic [31:0] IDENT_VALUE = 32'h0050_0001;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	// control: bit 0 run enable
	localparam int CTRL_RUN_BIT = 0;
	// configuration fields
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_EDGE_BIT = 2;
	localparam int CFG_SRC_BIT = 3;
	localparam int CFG_P1OUT_BIT = 4;
	localparam int CFG_IDLE_BIT = 5;
	localparam int CFG_IRQ_ALL_BIT = 6;
	// interrupt status bits
	localparam int EVT_PERIOD_BIT = 0;
	localparam int EVT_DONE_BIT = 1;
	localparam int EVT_W = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_PER = 32'h0000_0000;
	localparam logic [31:0] RST_PH1 = 32'h0000_0000;
	localparam logic [7:0] RST_RPT = 8'h00;

	// mode field encoding
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ONESHOT = 2'h1;
	localparam logic [1:0] MODE_CONT = 2'h2;

	// packed from bit 6 down to bit 0, matching the field positions above
	typedef struct packed {
		logic irq_every_period;
		logic idle_level;
		logic phase1_level;
		logic trig_vsync;
		logic trig_falling;
		logic [1:0] mode;
	} pwg_cfg_type;

	typedef struct packed {
		logic [31:0] period;
		logic [31:0] phase1;
	} pwg_timing_type;

endpackage

/* File: hw/pwg_sync.sv */
// three-stage input synchroniser with agreement-based change detection
`timescale 1ns/100ps
module pwg_sync
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// asynchronous input
	input wire logic async_i,
	// synchronised level
	output logic level_o
);
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic next_level;

	always_comb
	begin
		next_stage = {stage[1:0], async_i};
		// first stage is only read by the second stage
		next_level = (stage[2] == stage[1]) ? stage[1] : level_o;
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			stage <= 3'h0;
			level_o <= 1'b0;
		end
		else
		begin
			stage <= next_stage;
			level_o <= next_level;
		end
	end
endmodule // pwg_sync

/* File: hw/pwg_top.sv */
// pwm waveform generator with avalon-mm register slave
//
// How it works
// - a 32-bit period counter sets the length of each output period
// - a 32-bit phase-one length is compared with the count to end phase one
// - one-shot mode emits repeat count plus one periods, then stops
// - mode field selects one-shot or endlessly repeating continuous operation
// - period and phase-one settings are shadowed and loaded only at period start
// - a hardware trigger edge, rising or falling by choice, starts one-shot
// - the sensor front end vertical sync may be chosen as the one-shot trigger
// - output sits at the software idle level when no waveform runs
// - interrupt and dma sync events are raised by waveform generation
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
module pwg_top
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// avalon-mm slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// trigger inputs
	input wire logic hw_trigger_i,
	input wire logic image_sensor_frontend_vsync_i,
	// waveform and events
	output logic pwm_o,
	output logic irq_o,
	output logic system_dma_controller_event_o
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_pipe;
	logic rst_b;

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_b = rst_pipe[1];

	// ----------------------------------------------------------------
	// trigger synchronisers
	// ----------------------------------------------------------------
	logic trig_lvl;
	logic vsync_lvl;

	pwg_sync u_trig_sync
	(
		.clock_i(clock_i),
		.rst_b_i(rst_b),
		.async_i(hw_trigger_i),
		.level_o(trig_lvl)
	);

	pwg_sync u_vsync_sync
	(
		.clock_i(clock_i),
		.rst_b_i(rst_b),
		.async_i(image_sensor_frontend_vsync_i),
		.level_o(vsync_lvl)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} pwg_state_type;

	pwg_state_type state, next_state;
	logic run_en, next_run_en;
	pwg_pkg::pwg_cfg_type cfg, next_cfg;
	logic [7:0] burst_repeat_count, next_rpt;
	pwg_pkg::pwg_timing_type shadow, next_shadow;
	pwg_pkg::pwg_timing_type active, next_active;
	logic [31:0] count, next_count;
	logic [7:0] left, next_left;
	logic [pwg_pkg::EVT_W-1:0] irq_stat, next_irq_stat;
	logic [pwg_pkg::EVT_W-1:0] irq_mask, next_irq_mask;
	logic prev_src, next_prev_src;
	logic next_pwm, next_irq, next_dma;
	logic [31:0] next_rdata;
	logic next_wait;
	logic launch;
	logic trig_edge;
	logic src_lvl;
	logic period_end;
	logic bus_acc;
	logic wr_ok;
	logic [pwg_pkg::EVT_W-1:0] evt;

	// byte-lane merge used by the period and phase-one registers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// ----------------------------------------------------------------
	// bus and register logic
	// ----------------------------------------------------------------
	// one wait cycle per access: request taken while waitrequest is high,
	// answered on the following edge with waitrequest low
	assign bus_acc = (avs_read_i || avs_write_i) && avs_waitrequest_o;
	assign wr_ok = avs_write_i && avs_waitrequest_o;

	always_comb
	begin
		next_wait = !(bus_acc);
		next_rdata = avs_readdata_o;
		next_run_en = run_en;
		next_cfg = cfg;
		next_rpt = burst_repeat_count;
		next_shadow = shadow;
		next_irq_mask = irq_mask;
		launch = 1'b0;
		// narrow registers live in byte lane 0 only
		if (wr_ok && hit(avs_address_i, pwg_pkg::OFS_CTRL) && avs_byteenable_i[0])
			next_run_en = avs_writedata_i[pwg_pkg::CTRL_RUN_BIT];
		if (wr_ok && hit(avs_address_i, pwg_pkg::OFS_CFG) && avs_byteenable_i[0])
			next_cfg = pwg_pkg::pwg_cfg_type'(avs_writedata_i[6:0]);
		if (wr_ok && hit(avs_address_i, pwg_pkg::OFS_LAUNCH))
			launch = avs_byteenable_i[0] && avs_writedata_i[0];
		if (wr_ok && hit(avs_address_i, pwg_pkg::OFS_RPT) && avs_byteenable_i[0])
			next_rpt = avs_writedata_i[7:0];
		// writes land in the shadow copy only
		if (wr_ok && hit(avs_address_i, pwg_pkg::OFS_PER))
			next_shadow.period = merge(shadow.period, avs_writedata_i, avs_byteenable_i);
		if (wr_ok && hit(avs_address_i, pwg_pkg::OFS_PH1))
			next_shadow.phase1 = merge(shadow.phase1, avs_writedata_i, avs_byteenable_i);
		if (wr_ok && hit(avs_address_i, pwg_pkg::OFS_IRQ_MASK) && avs_byteenable_i[0])
			next_irq_mask = avs_writedata_i[pwg_pkg::EVT_W-1:0];
		if (avs_read_i && avs_waitrequest_o)
		begin
			unique case (avs_address_i)
				pwg_pkg::OFS_IDENT: next_rdata = pwg_pkg::IDENT_VALUE;
				pwg_pkg::OFS_CTRL: next_rdata = {31'h0, run_en};
				pwg_pkg::OFS_CFG: next_rdata = {25'h0, cfg};
				pwg_pkg::OFS_RPT: next_rdata = {24'h0, burst_repeat_count};
				pwg_pkg::OFS_PER: next_rdata = shadow.period;
				pwg_pkg::OFS_PH1: next_rdata = shadow.phase1;
				pwg_pkg::OFS_IRQ_STAT: next_rdata = {30'h0, irq_stat};
				pwg_pkg::OFS_IRQ_MASK: next_rdata = {30'h0, irq_mask};
				pwg_pkg::OFS_STATE: next_rdata = {22'h0, state == ST_RUN, state == ST_ARMED,
					left};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
			run_en <= 1'b0;
			cfg <= '0;
			burst_repeat_count <= pwg_pkg::RST_RPT;
			shadow <= {pwg_pkg::RST_PER, pwg_pkg::RST_PH1};
			irq_mask <= '0;
		end
		else
		begin
			avs_waitrequest_o <= next_wait;
			avs_readdata_o <= next_rdata;
			run_en <= next_run_en;
			cfg <= next_cfg;
			burst_repeat_count <= next_rpt;
			shadow <= next_shadow;
			irq_mask <= next_irq_mask;
		end
	end

	// ----------------------------------------------------------------
	// waveform engine
	// ----------------------------------------------------------------
	// source choice between hardware pin and vertical sync
	assign src_lvl = cfg.trig_vsync ? vsync_lvl : trig_lvl;
	// edge polarity is programmable
	assign trig_edge = cfg.trig_falling ? (prev_src && !src_lvl) : (!prev_src && src_lvl);
	// period ends when the count reaches the loaded period
	assign period_end = (count >= active.period);

	always_comb
	begin
		next_state = state;
		next_count = count;
		next_active = active;
		next_left = left;
		next_prev_src = src_lvl;
		evt = '0;
		unique case (state)
			ST_IDLE:
			begin
				// a burst starts from whatever software has loaded
				if (run_en && cfg.mode == pwg_pkg::MODE_CONT)
					next_state = ST_RUN;
				else if (run_en && cfg.mode == pwg_pkg::MODE_ONESHOT)
					next_state = ST_ARMED;
				next_count = 32'h0000_0000;
				next_active = shadow;
				next_left = burst_repeat_count;
			end
			ST_ARMED:
			begin
				next_count = 32'h0000_0000;
				next_active = shadow;
				next_left = burst_repeat_count;
				if (!run_en || cfg.mode != pwg_pkg::MODE_ONESHOT)
					next_state = ST_IDLE;
				else if (launch || trig_edge)
					next_state = ST_RUN;
			end
			ST_RUN:
			begin
				next_count = count + 32'h0000_0001;
				if (!run_en || cfg.mode == pwg_pkg::MODE_OFF)
					next_state = ST_IDLE;
				else if (period_end)
				begin
					evt[pwg_pkg::EVT_PERIOD_BIT] = 1'b1;
					next_count = 32'h0000_0000;
					// new settings only at a period boundary
					next_active = shadow;
					// continuous mode loops without end
					if (cfg.mode == pwg_pkg::MODE_ONESHOT)
					begin
						// n + 1 periods, then back to armed
						if (left == 8'h00)
						begin
							evt[pwg_pkg::EVT_DONE_BIT] = 1'b1;
							next_state = ST_ARMED;
						end
						else
							next_left = left - 8'h01;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		// sticky status, set wins over write-one-to-clear
		next_irq_stat = irq_stat;
		if (wr_ok && hit(avs_address_i, pwg_pkg::OFS_IRQ_STAT) && avs_byteenable_i[0])
			next_irq_stat = irq_stat & ~avs_writedata_i[pwg_pkg::EVT_W-1:0];
		next_irq_stat = next_irq_stat | evt;
		next_irq = |(next_irq_stat & irq_mask);
		next_dma = cfg.irq_every_period ? evt[pwg_pkg::EVT_PERIOD_BIT] :
			evt[pwg_pkg::EVT_DONE_BIT];
		// phase one holds while the count is below its length
		// idle level whenever the engine does not run
		if (next_state == ST_RUN)
			next_pwm = (next_count < next_active.phase1) ? cfg.phase1_level :
				!cfg.phase1_level;
		else
			next_pwm = cfg.idle_level;
	end

	always_ff @(posedge clock_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= ST_IDLE;
			count <= 32'h0000_0000;
			active <= {pwg_pkg::RST_PER, pwg_pkg::RST_PH1};
			left <= pwg_pkg::RST_RPT;
			prev_src <= 1'b0;
			irq_stat <= '0;
			pwm_o <= 1'b0;
			irq_o <= 1'b0;
			system_dma_controller_event_o <= 1'b0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			active <= next_active;
			left <= next_left;
			prev_src <= next_prev_src;
			irq_stat <= next_irq_stat;
			pwm_o <= next_pwm;
			irq_o <= next_irq;
			system_dma_controller_event_o <= next_dma;
		end
	end
endmodule // pwg_top

/* File: dv/pwg_top_asserts.sv */
// port-level checks for the pwm waveform generator
`timescale 1ns/100ps
module pwg_chk
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// register bus
	input wire logic avs_write_i,
	input wire logic avs_read_i,
	input wire logic [7:0] avs_address_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic avs_waitrequest_o,
	// waveform and events
	input wire logic pwm_o,
	input wire logic irq_o,
	input wire logic system_dma_controller_event_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	logic run;
	logic [6:0] cfg;
	logic [1:0] mask;
	logic [7:0] per;
	logic [7:0] ph1;
	logic pwm_q;
	logic [5:0] gap;
	logic cont;
	assign cont = run && cfg[1:0] == pwg_pkg::MODE_CONT && ph1 != 8'h00 && ph1 <= per && per < 8'h10;
	// shadow of software settings, so no hierarchy is needed
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			{run, cfg, mask, per, ph1, pwm_q, gap} <= '0;
		end
		else
		begin
			pwm_q <= pwm_o;
			gap <= (cont && pwm_o == pwm_q) ? gap + 6'h01 : 6'h00;
			if (avs_write_i && !avs_waitrequest_o)
			begin
				case (avs_address_i)
					8'h04: run <= avs_writedata_i[0];
					8'h08: cfg <= avs_writedata_i[6:0];
					8'h20: mask <= avs_writedata_i[1:0];
					8'h14: per <= avs_writedata_i[7:0];
					8'h18: ph1 <= avs_writedata_i[7:0];
					default: ;
				endcase
			end
		end
	end
	property p_wait_answer;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_wait_answer: assert property (p_wait_answer) else $error("no answer");
	property p_wait_pulse;
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("long answer");
	property p_wait_cause;
		$fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i);
	endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("stray answer");
	property p_idle;
		($stable(cfg) && (!run || cfg[1:0] == pwg_pkg::MODE_OFF))[*2] |-> pwm_o == cfg[5];
	endproperty
	a_idle: assert property (p_idle) else $error("output not at idle level");
	property p_irq_masked;
		(mask == 2'h0)[*2] |-> !irq_o;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked irq");
	property p_dma_pulse;
		system_dma_controller_event_o |=> !system_dma_controller_event_o;
	endproperty
	a_dma_pulse: assert property (p_dma_pulse) else $error("dma event too long");
	property p_dma_run;
		system_dma_controller_event_o |-> $past(run);
	endproperty
	a_dma_run: assert property (p_dma_run) else $error("dma event while stopped");
	property p_cont;
		gap < 6'd40;
	endproperty
	a_cont: assert property (p_cont) else $error("continuous output stalled");
endmodule // pwg_chk
bind pwg_top pwg_chk i_chk
(
	.clock_i(clock_i),
	.rst_b_i(rst_b_i),
	.avs_write_i(avs_write_i),
	.avs_read_i(avs_read_i),
	.avs_address_i(avs_address_i),
	.avs_writedata_i(avs_writedata_i),
	.avs_waitrequest_o(avs_waitrequest_o),
	.pwm_o(pwm_o),
	.irq_o(irq_o),
	.system_dma_controller_event_o(system_dma_controller_event_o)
);

/* File: dv/pwg_load_model.sv */
// load on the pwm output: counts pulses, high cycles and last pulse width
`timescale 1ns/100ps
module pwg_load_model
(
	// clock and control
	input wire logic clock_i,
	input wire logic clear_i,
	// waveform
	input wire logic pwm_i,
	// observations
	output logic [15:0] edges_o,
	output logic [15:0] high_o,
	output logic [15:0] width_o
);
	logic prev;
	logic [15:0] run;
	always_ff @(posedge clock_i)
	begin
		prev <= pwm_i;
		run <= pwm_i ? run + 16'h0001 : 16'h0000;
		if (prev && !pwm_i)
			width_o <= run;
		edges_o <= clear_i ? 16'h0000 : edges_o + 16'(!prev && pwm_i);
		high_o <= clear_i ? 16'h0000 : high_o + 16'(pwm_i);
	end
endmodule // pwg_load_model

/* File: dv/tb_pwg_top.sv */
// self-checking bench for the pwm waveform generator
`timescale 1ns/100ps
module tb_pwg_top;
	logic clk;
	logic rst_b;
	logic [7:0] adr;
	logic rd;
	logic wr;
	logic [31:0] wd;
	logic [31:0] rdat;
	logic wreq;
	logic hw;
	logic vs;
	logic pwm;
	logic irq;
	logic dma;
	logic clr;
	logic [15:0] edges;
	logic [15:0] high;
	logic [15:0] width;
	logic [31:0] rv;
	int dma_n;
	int miscompares;
	int checked;
	pwg_top i_dut
	(
		.clock_i(clk),
		.rst_b_i(rst_b),
		.avs_address_i(adr),
		.avs_read_i(rd),
		.avs_write_i(wr),
		.avs_writedata_i(wd),
		.avs_byteenable_i(4'hf),
		.avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq),
		.hw_trigger_i(hw),
		.image_sensor_frontend_vsync_i(vs),
		.pwm_o(pwm),
		.irq_o(irq),
		.system_dma_controller_event_o(dma)
	);
	pwg_load_model i_load
	(
		.clock_i(clk),
		.clear_i(clr),
		.pwm_i(pwm),
		.edges_o(edges),
		.high_o(high),
		.width_o(width)
	);
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
		if (dma === 1'b1)
			dma_n++;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// holds the request until the edge that sees waitrequest low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk); while (wreq !== 1'b0);
		rv = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic end_of_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_regs;
		bus(1'b0, 8'h00, 32'h0000_0000);
		chk(rv, pwg_pkg::IDENT_VALUE);
		bus(1'b1, 8'h14, 32'h1234_5678);
		bus(1'b0, 8'h14, 32'h0000_0000);
		chk(rv, 32'h1234_5678);
		bus(1'b0, 8'h3c, 32'h0000_0000);
		chk(rv, 32'h0000_0000);
	endtask
	// k: 0 launch write, 1 rising pin, 2 falling pin, 3 vertical sync
	task automatic t_oneshot(input int k, input logic [7:0] n);
		logic [31:0] c;
		c = 32'h0000_0011;
		c[pwg_pkg::CFG_EDGE_BIT] = (k == 2);
		c[pwg_pkg::CFG_SRC_BIT] = (k == 3);
		hw <= (k == 2);
		bus(1'b1, 8'h20, (k != 0) ? 32'h0000_0002 : 32'h0000_0000);
		bus(1'b1, 8'h08, c);
		bus(1'b1, 8'h10, {24'h00_0000, n});
		bus(1'b1, 8'h14, 32'h0000_0005);
		bus(1'b1, 8'h18, 32'h0000_0002);
		bus(1'b1, 8'h04, 32'h0000_0001);
		clr <= 1'b1;
		dma_n = 0;
		repeat (8) @(posedge clk);
		clr <= 1'b0;
		if (k == 0)
			bus(1'b1, 8'h0c, 32'h0000_0001);
		else if (k == 3)
			vs <= 1'b1;
		else
			hw <= !hw;
		do bus(1'b0, 8'h1c, 32'h0000_0000); while (rv[pwg_pkg::EVT_DONE_BIT] !== 1'b1);
		chk({16'h0000, edges}, 32'(n) + 32'h0000_0001);
		chk({16'h0000, high}, (32'(n) + 32'h0000_0001) * 32'h0000_0002);
		chk(32'(dma_n), 32'h0000_0001);
		chk({31'h0, irq}, 32'(k != 0));
		bus(1'b1, 8'h1c, 32'h0000_0003);
		bus(1'b1, 8'h04, 32'h0000_0000);
		vs <= 1'b0;
		hw <= 1'b0;
		bus(1'b0, 8'h1c, 32'h0000_0000);
		chk(rv, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
	endtask
	task automatic t_cont;
		bus(1'b1, 8'h08, 32'h0000_0012);
		bus(1'b1, 8'h14, 32'h0000_0009);
		bus(1'b1, 8'h18, 32'h0000_0004);
		bus(1'b1, 8'h04, 32'h0000_0001);
		do @(posedge clk); while (pwm);
		do @(posedge clk); while (!pwm);
		bus(1'b1, 8'h18, 32'h0000_0007);
		do @(posedge clk); while (pwm);
		@(posedge clk);
		chk({16'h0000, width}, 32'h0000_0004);
		do @(posedge clk); while (!pwm);
		do @(posedge clk); while (pwm);
		@(posedge clk);
		chk({16'h0000, width}, 32'h0000_0007);
		bus(1'b1, 8'h04, 32'h0000_0000);
		bus(1'b1, 8'h08, 32'h0000_0020);
		repeat (3) @(posedge clk);
		chk({31'h0, pwm}, 32'h0000_0001);
	endtask
	initial
	begin
		{rst_b, adr, rd, wr, wd, hw, vs} = '0;
		clr = 1'b1;
		dma_n = 0;
		miscompares = 0;
		checked = 0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs;
		t_oneshot(0, 8'h00);
		t_oneshot(1, 8'h03);
		t_oneshot(2, 8'h02);
		t_oneshot(3, 8'hff);
		t_cont;
		end_of_test;
	end
	// about 40000 cycles, far beyond the expected run
	initial
	begin
		#2000000;
		miscompares++;
		end_of_test;
	end
endmodule // tb_pwg_top
